// >>> rtl/osp_pkg.sv
// Package: constants, register map and carrier types for the option sync/status parameter bank
package osp_pkg;

    // Clock and update tick
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
    localparam int unsigned TICK_PERIOD_NS = 250000; // 250 us
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // Register byte offsets
    localparam logic [7:0] OFS_SC_EN = 8'h00;
    localparam logic [7:0] OFS_AO_ONE = 8'h04;
    localparam logic [7:0] OFS_AO_TWO = 8'h08;
    localparam logic [7:0] OFS_DIN_STAT = 8'h0C;
    localparam logic [7:0] OFS_CNT_BASE = 8'h10;
    localparam logic [7:0] OFS_CNT_STEP = 8'h04;
    localparam logic [7:0] OFS_ROLE_CTL = 8'h20;
    localparam logic [7:0] OFS_ROLE_STAT = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h2C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h30;

    // Field positions
    localparam int unsigned SC_AO_ONE_BIT = 3;
    localparam int unsigned SC_AO_TWO_BIT = 4;
    localparam int unsigned CNT_GOOD = 0;
    localparam int unsigned CNT_BAD = 1;
    localparam int unsigned CNT_MISSING = 2;
    localparam int unsigned CNT_WIDTH = 3;
    localparam int unsigned IRQ_ROLE_BIT = 4;

    // Reset values and limits
    localparam logic [7:0] SC_EN_RESET = 8'h00;
    localparam logic [10:0] AO_RESET = 11'h000;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [1:0] ROLE_CTL_RESET = 2'h0;
    localparam logic [7:0] ROLE_CTL_MAX = 8'h02;
    localparam logic [4:0] IRQ_RESET = 5'h00;
    localparam logic [15:0] TICK_RESET = 16'h0000;

    // Analog full scale: code +/-1023 is +/-21.4 mA or +/-10 V
    localparam logic [10:0] AO_FS_POS = 11'h3FF;
    localparam logic [10:0] AO_FS_NEG = 11'h401;
    localparam logic [10:0] AO_MOST_NEG = 11'h400;
    localparam int unsigned AO_FS_CURRENT_UA = 21400;
    localparam int unsigned AO_FS_VOLTAGE_MV = 10000;

    // Bus state, Gray coded along idle -> write / idle -> read wait
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WR = 2'b01,
        ST_RD = 2'b10
    } osp_bus_st_t;

    // Levels from the host drive
    typedef struct packed {
        logic [5:0] gen_in;
        logic drive_enable;
        logic polarity_neg;
        logic [6:0] invert;
        logic [1:0] ao_high_speed;
        logic [1:0] ao_current_mode;
        logic producer_granted;
        logic producer_elsewhere;
        logic rate_compatible;
        logic drive_locked;
    } osp_drv_in_t;

    // One-cycle pulses from the sync message receiver
    typedef struct packed {
        logic width_err;
        logic msg_missing;
        logic msg_bad;
        logic msg_good;
    } osp_evt_t;

    // Analog output shortcut toward the drive
    typedef struct packed {
        logic [10:0] value_one;
        logic [10:0] value_two;
        logic [1:0] valid;
        logic [1:0] current_mode;
    } osp_ao_t;

    // Whole state of the bank
    typedef struct packed {
        osp_bus_st_t st;
        logic [7:0] addr;
        logic hready;
        logic [31:0] hrdata;
        osp_drv_in_t s1;
        osp_drv_in_t s2;
        logic [15:0] tick_cnt;
        logic tick;
        logic [7:0] sc_en;
        logic [10:0] ao_set_one;
        logic [10:0] ao_set_two;
        osp_ao_t ao;
        logic [7:0] din_stat;
        logic [3:0][31:0] cnt;
        logic [1:0] role_ctl;
        logic [7:0] role_stat;
        logic [4:0] istat;
        logic [4:0] ien;
        logic irq;
    } osp_state_t;

endpackage : osp_pkg

// >>> rtl/osp_param_bank.sv
// Module: AHB-Lite parameter bank for analog shortcut, input status, sync counters and sync roles
//
// Contract
// - Enabled analog shortcut drives the drive's analog outputs from the two value registers.
// - Analog values transfer only while that drive output is not in high speed mode.
// - Shortcut values pass unscaled; the current range choice never alters scaling.
// - Output type, current or voltage, still follows the drive's analog output mode.
// - Current mode: signed +/-1023 means +/-21.4 mA full scale.
// - Voltage mode: signed +/-1023 means +/-10 V full scale.
// - Input status: inputs one to six in bits 0-5, enable in bit 6, bit 7 zero.
// - Each input bit is taken after logic polarity and per-input inversion.
// - Signed 32-bit counter counts sync messages received with valid checksum.
// - Separate signed 32-bit counter counts sync messages received with bad checksum.
// - Third 32-bit counter counts expected sync messages that never arrived.
// - Fourth 32-bit counter counts sync pulses of incorrect width, per sync event.
// - Role control, range 0 to 2, resets to 0; bit 0 requests producer.
// - Role control bit 1 requests taking part as consumer.
// - Status bits 0 and 1 mirror control bits 1 and 0; bits 7-4 zero.
// - Status bit 2 shows producer obtained; competing producers do not all see it.
// - Consumer bit 2 needs no producer request, remote producer used, compatible rate.
// - Status bit 3, locked within tolerance, only while status bits 2-0 are 1,0,1.
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module osp_param_bank #(
    parameter int unsigned TICK_CYCLES = osp_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output var logic hreadyout,
    output var logic hresp,
    output var logic [31:0] hrdata,
    input wire osp_pkg::osp_drv_in_t drv_in,
    input wire osp_pkg::osp_evt_t sync_evt,
    output var osp_pkg::osp_ao_t ao_out,
    output var logic irq
);

    osp_pkg::osp_state_t st_r;
    osp_pkg::osp_state_t st_nxt;
    logic [3:0] evt_vec;
    logic [3:0] cnt_wr_hit;
    logic wr_phase;
    logic prod_req;
    logic cons_req;
    logic role_got;
    logic [6:0] din_raw;

    // One-hot select of the health counter at an address
    function automatic logic [3:0] osp_cnt_sel(input logic [7:0] a);
        logic [3:0] sel;
        sel = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (a == 8'(osp_pkg::OFS_CNT_BASE + 8'(i) * osp_pkg::OFS_CNT_STEP)) begin
                sel[i] = 1'b1;
            end
        end
        return sel;
    endfunction : osp_cnt_sel

    // Limit a written code to the symmetric +/-1023 range
    function automatic logic [10:0] osp_ao_clamp(input logic [10:0] v);
        return (v == osp_pkg::AO_MOST_NEG) ? osp_pkg::AO_FS_NEG : v;
    endfunction : osp_ao_clamp

    // Read multiplexer; unmapped and write-only offsets read zero
    function automatic logic [31:0] osp_read(input osp_pkg::osp_state_t s, input logic [7:0] a);
        logic [31:0] d;
        logic [3:0] sel;
        d = 32'h0000_0000;
        sel = osp_cnt_sel(a);
        case (a)
            osp_pkg::OFS_SC_EN: d = {24'h000000, s.sc_en};
            osp_pkg::OFS_AO_ONE: d = {{21{s.ao_set_one[10]}}, s.ao_set_one};
            osp_pkg::OFS_AO_TWO: d = {{21{s.ao_set_two[10]}}, s.ao_set_two};
            osp_pkg::OFS_DIN_STAT: d = {24'h000000, s.din_stat};
            osp_pkg::OFS_ROLE_CTL: d = {30'h0000_0000, s.role_ctl};
            osp_pkg::OFS_ROLE_STAT: d = {24'h000000, s.role_stat};
            osp_pkg::OFS_IRQ_STAT: d = {27'h0000000, s.istat};
            osp_pkg::OFS_IRQ_EN: d = {27'h0000000, s.ien};
            default: begin
                for (int i = 0; i < 4; i++) begin
                    if (sel[i]) begin
                        d = s.cnt[i];
                    end
                end
            end
        endcase
        return d;
    endfunction : osp_read

    // Event pulses in counter order
    assign evt_vec = {sync_evt.width_err, sync_evt.msg_missing, sync_evt.msg_bad, sync_evt.msg_good};
    assign wr_phase = (st_r.st == osp_pkg::ST_WR);
    assign cnt_wr_hit = wr_phase ? osp_cnt_sel(st_r.addr) : 4'h0;
    assign prod_req = st_r.role_ctl[0];
    assign cons_req = st_r.role_ctl[1];
    assign din_raw = {st_r.s2.drive_enable, st_r.s2.gen_in};

    // Producer granted by drive arbitration, or consumer without producer request using a rate-compatible remote producer
    assign role_got = (prod_req & st_r.s2.producer_granted)
                    | (cons_req & ~prod_req & st_r.s2.producer_elsewhere & st_r.s2.rate_compatible);

    // Next state of the whole bank
    always_comb begin
        st_nxt = st_r;
        // Pin synchronisers
        st_nxt.s1 = drv_in;
        st_nxt.s2 = st_r.s1;
        // Update tick divider
        if (st_r.tick_cnt == 16'(TICK_CYCLES - 1)) begin
            st_nxt.tick_cnt = osp_pkg::TICK_RESET;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
            st_nxt.tick = 1'b0;
        end
        // Write data phase commits to the latched address
        if (wr_phase) begin
            case (st_r.addr)
                osp_pkg::OFS_SC_EN: st_nxt.sc_en = hwdata[7:0];
                osp_pkg::OFS_AO_ONE: st_nxt.ao_set_one = osp_ao_clamp(hwdata[10:0]);
                osp_pkg::OFS_AO_TWO: st_nxt.ao_set_two = osp_ao_clamp(hwdata[10:0]);
                osp_pkg::OFS_ROLE_CTL: begin
                    if (hwdata[7:0] <= osp_pkg::ROLE_CTL_MAX && hwdata[31:8] == 24'h000000) begin
                        st_nxt.role_ctl = hwdata[1:0];
                    end
                end
                osp_pkg::OFS_IRQ_EN: st_nxt.ien = hwdata[4:0];
                default: st_nxt.ien = st_r.ien;
            endcase
        end
        // Health counters: load on write, then count, wrapping at 32 bits
        for (int i = 0; i < 4; i++) begin
            st_nxt.cnt[i] = (cnt_wr_hit[i] ? hwdata : st_r.cnt[i])
                          + {31'h00000000, evt_vec[i]};
        end
        // Role status: mirrored requests, achieved role, lock
        st_nxt.role_stat[0] = st_r.role_ctl[1];
        st_nxt.role_stat[1] = st_r.role_ctl[0];
        st_nxt.role_stat[2] = role_got;
        st_nxt.role_stat[3] = ({role_got, st_r.role_ctl[0], st_r.role_ctl[1]} == 3'b101)
                            & st_r.s2.drive_locked;
        st_nxt.role_stat[7:4] = 4'h0;
        // Sticky interrupt status; a new event wins over a clear
        st_nxt.istat = st_r.istat & ~((wr_phase && st_r.addr == osp_pkg::OFS_IRQ_CLR) ? hwdata[4:0] : 5'h00);
        st_nxt.istat = st_nxt.istat | {st_nxt.role_stat[2] ^ st_r.role_stat[2], evt_vec};
        st_nxt.irq = |(st_nxt.istat & st_nxt.ien);
        // Shortcut output type follows the drive mode at all times
        st_nxt.ao.current_mode = st_r.s2.ao_current_mode;
        // Tick-rate updates: inputs and analog shortcut
        if (st_r.tick) begin
            st_nxt.din_stat = {1'b0, din_raw ^ st_r.s2.invert ^ {7{st_r.s2.polarity_neg}}};
            st_nxt.ao.valid[0] = st_r.sc_en[osp_pkg::SC_AO_ONE_BIT] & ~st_r.s2.ao_high_speed[0];
            st_nxt.ao.valid[1] = st_r.sc_en[osp_pkg::SC_AO_TWO_BIT] & ~st_r.s2.ao_high_speed[1];
            if (st_nxt.ao.valid[0]) begin
                st_nxt.ao.value_one = st_r.ao_set_one;
            end
            if (st_nxt.ao.valid[1]) begin
                st_nxt.ao.value_two = st_r.ao_set_two;
            end
        end
        // Bus sequencing: reads get one wait state so a preceding write is seen
        case (st_r.st)
            osp_pkg::ST_RD: begin
                st_nxt.hrdata = osp_read(st_r, st_r.addr);
                st_nxt.hready = 1'b1;
                st_nxt.st = osp_pkg::ST_IDLE;
            end
            osp_pkg::ST_IDLE, osp_pkg::ST_WR: begin
                st_nxt.st = osp_pkg::ST_IDLE;
                st_nxt.hready = 1'b1;
                if (hsel && htrans[1] && hready) begin
                    st_nxt.addr = haddr[7:0];
                    if (hwrite) begin
                        st_nxt.st = osp_pkg::ST_WR;
                    end else begin
                        st_nxt.st = osp_pkg::ST_RD;
                        st_nxt.hready = 1'b0;
                    end
                end
            end
            default: begin
                st_nxt.st = osp_pkg::ST_IDLE;
                st_nxt.hready = 1'b1;
            end
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.st <= osp_pkg::ST_IDLE;
            st_r.hready <= 1'b1;
            st_r.sc_en <= osp_pkg::SC_EN_RESET;
            st_r.ao_set_one <= osp_pkg::AO_RESET;
            st_r.ao_set_two <= osp_pkg::AO_RESET;
            st_r.cnt <= {4{osp_pkg::CNT_RESET}};
            st_r.role_ctl <= osp_pkg::ROLE_CTL_RESET;
            st_r.istat <= osp_pkg::IRQ_RESET;
            st_r.ien <= osp_pkg::IRQ_RESET;
            st_r.tick_cnt <= osp_pkg::TICK_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register, except hresp tied low
    assign hreadyout = st_r.hready;
    assign hresp = 1'b0;
    assign hrdata = st_r.hrdata;
    assign ao_out = st_r.ao;
    assign irq = st_r.irq;

    default clocking osp_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence seq_rd_req;
        hsel && htrans[1] && !hwrite && hready;
    endsequence

    sequence seq_rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    sequence seq_tick_ao_one;
        st_r.tick && st_r.sc_en[osp_pkg::SC_AO_ONE_BIT] && !st_r.s2.ao_high_speed[0];
    endsequence

    sequence seq_tick_ao_two;
        st_r.tick && st_r.sc_en[osp_pkg::SC_AO_TWO_BIT] && !st_r.s2.ao_high_speed[1];
    endsequence

    AST_RD_WAIT: assert property (seq_rd_req |=> seq_rd_answer)
        else $error("read not answered after one wait state");

    AST_AO_TRANSFER: assert property (seq_tick_ao_one |=>
        ao_out.valid[0] && ao_out.value_one == $past(st_r.ao_set_one))
        else $error("analog value one not transferred on tick");

    AST_AO_TRANSFER_TWO: assert property (seq_tick_ao_two |=>
        ao_out.valid[1] && ao_out.value_two == $past(st_r.ao_set_two))
        else $error("analog value two not transferred on tick");

    AST_AO_HS_ONE: assert property (st_r.tick && st_r.s2.ao_high_speed[0] |=> !ao_out.valid[0])
        else $error("analog value one transferred in high speed mode");

    AST_AO_RANGE_ONE: assert property (ao_out.value_one != osp_pkg::AO_MOST_NEG)
        else $error("analog value one beyond full scale");

    AST_AO_RANGE_TWO: assert property (ao_out.value_two != osp_pkg::AO_MOST_NEG)
        else $error("analog value two beyond full scale");

    AST_AO_HIGH_SPEED: assert property (st_r.tick && st_r.s2.ao_high_speed[1] |=> !ao_out.valid[1])
        else $error("analog value two transferred in high speed mode");

    AST_AO_HOLD: assert property (!st_r.tick |=> $stable(ao_out.value_one) && $stable(ao_out.value_two))
        else $error("analog value changed between ticks");

    AST_AO_MODE: assert property (##1 ao_out.current_mode == $past(st_r.s2.ao_current_mode))
        else $error("analog output type does not follow drive mode");

    AST_DIN_MAP: assert property (st_r.tick |=> st_r.din_stat == {1'b0, $past(din_raw ^ st_r.s2.invert)
        ^ {7{$past(st_r.s2.polarity_neg)}}})
        else $error("input status not polarity corrected");

    AST_DIN_RSV: assert property (st_r.din_stat[7] == 1'b0)
        else $error("input status bit 7 not zero");

    AST_CNT_GOOD: assert property (sync_evt.msg_good && !cnt_wr_hit[0] |=>
        st_r.cnt[0] == $past(st_r.cnt[0]) + 32'h1)
        else $error("good message counter did not count");

    AST_CNT_BAD: assert property (sync_evt.msg_bad && !cnt_wr_hit[1] |=>
        st_r.cnt[1] == $past(st_r.cnt[1]) + 32'h1)
        else $error("bad message counter did not count");

    AST_CNT_MISS: assert property (sync_evt.msg_missing && !cnt_wr_hit[2] |=>
        st_r.cnt[2] == $past(st_r.cnt[2]) + 32'h1)
        else $error("missing message counter did not count");

    AST_CNT_WIDTH_INC: assert property (sync_evt.width_err && !cnt_wr_hit[3] |=>
        st_r.cnt[3] == $past(st_r.cnt[3]) + 32'h1)
        else $error("width error counter did not count");

    AST_CNT_WIDTH: assert property (!sync_evt.width_err && !cnt_wr_hit[3] |=> $stable(st_r.cnt[3]))
        else $error("width error counter moved without an event");

    AST_CNT_GOOD_HOLD: assert property (!sync_evt.msg_good && !cnt_wr_hit[0] |=> $stable(st_r.cnt[0]))
        else $error("good message counter moved without an event");

    AST_CNT_BAD_HOLD: assert property (!sync_evt.msg_bad && !cnt_wr_hit[1] |=> $stable(st_r.cnt[1]))
        else $error("bad message counter moved without an event");

    AST_CNT_MISS_HOLD: assert property (!sync_evt.msg_missing && !cnt_wr_hit[2] |=> $stable(st_r.cnt[2]))
        else $error("missing message counter moved without an event");

    AST_CNT_LOAD: assert property (cnt_wr_hit[1] |=>
        st_r.cnt[1] == $past(hwdata) + {31'h0, $past(sync_evt.msg_bad)})
        else $error("counter write did not load");

    AST_CNT_LOAD_GOOD: assert property (cnt_wr_hit[0] |=>
        st_r.cnt[0] == $past(hwdata) + {31'h0, $past(sync_evt.msg_good)})
        else $error("good counter write did not load");

    AST_CTL_RANGE: assert property (st_r.role_ctl != 2'b11)
        else $error("role control outside 0 to 2");

    AST_STAT_MIRROR: assert property (##1 st_r.role_stat[1:0] == {$past(st_r.role_ctl[0]), $past(st_r.role_ctl[1])}
        && st_r.role_stat[7:4] == 4'h0)
        else $error("role status does not mirror control");

    AST_ROLE_PROD: assert property (st_r.role_stat[2] && st_r.role_stat[1] |->
        $past(st_r.s2.producer_granted))
        else $error("producer role shown without grant");

    AST_ROLE_CONS: assert property (st_r.role_stat[2] && !st_r.role_stat[1]
        |-> $past(st_r.s2.producer_elsewhere && st_r.s2.rate_compatible && cons_req))
        else $error("consumer role shown without usable producer");

    AST_LOCK: assert property (st_r.role_stat[3] |-> st_r.role_stat[2:0] == 3'b101)
        else $error("lock bit set outside 1,0,1");

    AST_LOCK_DRIVE: assert property (st_r.role_stat[3] |-> $past(st_r.s2.drive_locked))
        else $error("lock bit set while drive unlocked");

    AST_ROLE_UNREQ: assert property (st_r.role_stat[1:0] == 2'b00 |-> !st_r.role_stat[2])
        else $error("role achieved without a request");

    AST_IRQ_LEVEL: assert property (irq == |(st_r.istat & st_r.ien))
        else $error("interrupt level does not follow enabled status");

    AST_IRQ_SET: assert property (|evt_vec |=> (st_r.istat[3:0] & $past(evt_vec)) == $past(evt_vec))
        else $error("event did not set its status bit");

    AST_IRQ_STICKY: assert property (st_r.istat[0] && !(wr_phase && st_r.addr == osp_pkg::OFS_IRQ_CLR && hwdata[0])
        |=> st_r.istat[0])
        else $error("status bit dropped without a clear");

    AST_WR_NO_WAIT: assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout)
        else $error("write given a wait state");

endmodule : osp_param_bank

`default_nettype wire

// >>> testbench/osp_drive_model.sv
// Host drive stand-in: pin levels and sync receiver pulses
`timescale 1ns/10ps
`default_nettype none

module osp_drive_model (
    input wire logic hclk,
    output var osp_pkg::osp_drv_in_t drv_in,
    output var osp_pkg::osp_evt_t sync_evt,
    input wire osp_pkg::osp_ao_t ao_out
);
    // Quiet pins at time zero
    initial begin
        drv_in = '0;
        sync_evt = '0;
    end

    // New pin levels just after an edge
    task automatic drive(input osp_pkg::osp_drv_in_t v);
        @(posedge hclk);
        drv_in <= v;
    endtask : drive

    // One-cycle receiver pulse, released at the next edge
    task automatic pulse(input osp_pkg::osp_evt_t e);
        @(posedge hclk);
        sync_evt <= e;
        @(posedge hclk);
        sync_evt <= '0;
    endtask : pulse
endmodule : osp_drive_model
`default_nettype wire

// >>> testbench/option_sync_status_params_tb.sv
// Self-checking bench for the option sync/status parameter bank
`timescale 1ns/10ps
`default_nettype none

module option_sync_status_params_tb;
    localparam int unsigned TK = 8;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [31:0] hrdata;
    osp_pkg::osp_drv_in_t drv_in;
    osp_pkg::osp_drv_in_t lv;
    osp_pkg::osp_evt_t sync_evt;
    osp_pkg::osp_ao_t ao_out;
    int n_fail = 0;
    int compares = 0;

    // 25 MHz clock
    always #20 hclk = ~hclk;

    // Bank under test, short tick
    osp_param_bank #(.TICK_CYCLES(TK)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .drv_in(drv_in),
        .sync_evt(sync_evt), .ao_out(ao_out), .irq(irq)
    );

    // Host drive side
    osp_drive_model u_host (.hclk(hclk), .drv_in(drv_in), .sync_evt(sync_evt), .ao_out(ao_out));

    // Verdict and end of run
    task automatic conclude;
        if (n_fail == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Single word transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask : wr

    // Register read compared against expectation
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(nm, exp, q);
    endtask : rd_chk

    task automatic wt(input int n);
        repeat (n) @(posedge hclk);
    endtask : wt

    // Values straight after reset, unmapped read
    task automatic t_reset;
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("irq", 32'h0, {31'h0, irq});
        rd_chk("role_ctl", osp_pkg::OFS_ROLE_CTL, 32'h0);
        rd_chk("role_stat", osp_pkg::OFS_ROLE_STAT, 32'h0);
        rd_chk("unmapped", 8'h3C, 32'h0);
    endtask : t_reset

    // Health counters, single and simultaneous events, wrap and load
    task automatic t_count;
        logic [3:0] ev [8] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h8, 4'h8, 4'h8, 4'hF};
        logic [31:0] exp [4] = '{32'h3, 32'h2, 32'h2, 32'h4};
        for (int i = 0; i < 8; i++) begin
            u_host.pulse(ev[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rd_chk("counter", osp_pkg::OFS_CNT_BASE + 8'(4 * i), exp[i]);
        end
        wr(osp_pkg::OFS_CNT_BASE, 32'hFFFFFFFF);
        wr(osp_pkg::OFS_CNT_BASE + 8'h04, 32'h7FFFFFFF);
        wr(osp_pkg::OFS_CNT_BASE + 8'h08, 32'h12345678);
        u_host.pulse(4'h3);
        rd_chk("good_wrap", osp_pkg::OFS_CNT_BASE, 32'h0);
        rd_chk("bad_wrap", osp_pkg::OFS_CNT_BASE + 8'h04, 32'h80000000);
        rd_chk("miss_load", osp_pkg::OFS_CNT_BASE + 8'h08, 32'h12345678);
    endtask : t_count

    // Interrupt raised, masked and cleared
    task automatic t_irq;
        wr(osp_pkg::OFS_IRQ_CLR, 32'h1F);
        wr(osp_pkg::OFS_IRQ_EN, 32'h01);
        wt(2);
        chk("irq_idle", 32'h0, {31'h0, irq});
        u_host.pulse(4'h1);
        wt(2);
        chk("irq_set", 32'h1, {31'h0, irq});
        u_host.pulse(4'h2);
        wr(osp_pkg::OFS_IRQ_CLR, 32'h01);
        wt(2);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd_chk("irq_stat", osp_pkg::OFS_IRQ_STAT, 32'h2);
        wr(osp_pkg::OFS_IRQ_EN, 32'h0);
        wr(osp_pkg::OFS_IRQ_CLR, 32'h1F);
    endtask : t_irq

    // Input status packing, polarity and inversion
    task automatic t_din;
        lv.gen_in = 6'h2A;
        lv.drive_enable = 1'b1;
        u_host.drive(lv);
        wt(3 * TK + 4);
        rd_chk("din", osp_pkg::OFS_DIN_STAT, 32'h6A);
        lv.polarity_neg = 1'b1;
        lv.invert = 7'h01;
        u_host.drive(lv);
        wt(3 * TK + 4);
        rd_chk("din_inv", osp_pkg::OFS_DIN_STAT, 32'h14);
    endtask : t_din

    // Analog shortcut: high speed block, mode follow, full scale, clamp
    task automatic t_ao;
        lv.ao_high_speed = 2'h2;
        lv.ao_current_mode = 2'h1;
        u_host.drive(lv);
        wr(osp_pkg::OFS_AO_ONE, 32'h64);
        wr(osp_pkg::OFS_AO_TWO, 32'hFFFFFC01);
        wr(osp_pkg::OFS_SC_EN, 32'h18);
        wt(2 * TK + 4);
        chk("ao_valid", 32'h1, {30'h0, ao_out.valid});
        chk("ao_one", 32'h64, {21'h0, ao_out.value_one});
        chk("ao_mode", 32'h1, {30'h0, ao_out.current_mode});
        chk("ao_two_hs", 32'h0, {21'h0, ao_out.value_two});
        lv.ao_high_speed = 2'h0;
        lv.ao_current_mode = 2'h2;
        u_host.drive(lv);
        wt(2 * TK + 4);
        chk("ao_valid2", 32'h3, {30'h0, ao_out.valid});
        chk("ao_two", 32'h401, {21'h0, ao_out.value_two});
        chk("ao_mode2", 32'h2, {30'h0, ao_out.current_mode});
        wr(osp_pkg::OFS_AO_ONE, 32'hFFFFFC00);
        rd_chk("ao_clamp", osp_pkg::OFS_AO_ONE, 32'hFFFFFC01);
        wr(osp_pkg::OFS_SC_EN, 32'h0);
        wt(2 * TK + 4);
        chk("ao_off", 32'h0, {30'h0, ao_out.valid});
    endtask : t_ao

    // Producer and consumer roles, refused value, lock bit
    task automatic t_role;
        lv.producer_granted = 1'b1;
        lv.producer_elsewhere = 1'b1;
        lv.rate_compatible = 1'b1;
        lv.drive_locked = 1'b1;
        u_host.drive(lv);
        wt(4);
        wr(osp_pkg::OFS_ROLE_CTL, 32'h1);
        rd_chk("stat_prod", osp_pkg::OFS_ROLE_STAT, 32'h06);
        wr(osp_pkg::OFS_ROLE_CTL, 32'h3);
        rd_chk("ctl_refused", osp_pkg::OFS_ROLE_CTL, 32'h1);
        wr(osp_pkg::OFS_ROLE_CTL, 32'h2);
        rd_chk("stat_cons", osp_pkg::OFS_ROLE_STAT, 32'h0D);
        lv.rate_compatible = 1'b0;
        u_host.drive(lv);
        wt(4);
        rd_chk("stat_rate", osp_pkg::OFS_ROLE_STAT, 32'h01);
        lv.producer_granted = 1'b0;
        u_host.drive(lv);
        wt(4);
        wr(osp_pkg::OFS_ROLE_CTL, 32'h1);
        rd_chk("stat_denied", osp_pkg::OFS_ROLE_STAT, 32'h02);
    endtask : t_role

    // Main sequence
    initial begin
        lv = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_count();
        t_irq();
        t_din();
        t_ao();
        t_role();
        conclude();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge hclk);
        n_fail++;
        conclude();
    end
endmodule : option_sync_status_params_tb
`default_nettype wire
